// ---- tb/memory_map_control_regs_tb.sv ----
`timescale 1ns/10ps
module memory_map_control_regs_tb;
  logic clk;
  logic reset_n;
  memory_map_control_pkg::op_mode_t mode;
  memory_map_control_pkg::size_switches_t sizeSwitches;
  memory_map_control_pkg::reg_request_t request;
  logic [7:0] readData;
  memory_map_control_pkg::memory_map_t memoryMap;
  logic [4:0] blk;
  int badCount;
  int checkCount;

  memory_map_control_regs DUT (
    .clk(clk),
    .reset_n(reset_n),
    .mode(mode),
    .sizeSwitches(sizeSwitches),
    .request(request),
    .readData(readData),
    .memoryMap(memoryMap)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // blk tracks where software believes the block sits; it must follow every base move
  task automatic wr(input logic [5:0] off, input logic [7:0] data);
    @(posedge clk);
    request.addr <= {blk, 5'h00, off};
    request.writeData <= data;
    request.writeStrobe <= 1'b1;
    @(posedge clk);
    request.writeStrobe <= 1'b0;
    #1;
  endtask

  // read data is only valid in the single cycle after the strobe edge
  task automatic rd(input logic [5:0] off, input logic [7:0] exp);
    @(posedge clk);
    request.addr <= {blk, 5'h00, off};
    request.readStrobe <= 1'b1;
    @(posedge clk);
    request.readStrobe <= 1'b0;
    #1;
    check(16'(readData), 16'(exp));
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    blk = 5'h00;
  endtask

  task automatic test_reset_values();
    rd(6'h10, 8'h09);
    @(posedge clk);
    #1 check(16'(readData), 16'h0000);
    rd(6'h11, 8'h00);
    rd(6'h12, 8'h01);
    rd(6'h13, 8'h01);
    rd(6'h14, 8'h00);
    rd(6'h17, 8'h00);
    rd(6'h30, 8'h00);
    rd(6'h31, 8'h00);
    check(16'(memoryMap.ramBase), 16'h0001);
    check(16'(memoryMap.ramHighAlign), 16'h0001);
    check(16'(memoryMap.programMemoryEnable), 16'h0001);
    check(16'(memoryMap.registerSpaceBase), 16'h0000);
    check(16'(memoryMap.eepromBase), 16'h0000);
    check(16'(memoryMap.eepromEnable), 16'h0001);
    check(16'(memoryMap.externalStretch), 16'h0000);
    check(16'(memoryMap.programHighMapOnly), 16'h0000);
    check(16'(memoryMap.programPage), 16'h0000);
  endtask

  task automatic test_size_switches();
    @(posedge clk);
    sizeSwitches <= 10'b1_10_101_01_11;
    rd(6'h1c, 8'ha5);
    rd(6'h1d, 8'h43);
    wr(6'h1c, 8'h00);
    wr(6'h1d, 8'hff);
    rd(6'h1c, 8'ha5);
    rd(6'h1d, 8'h43);
    @(posedge clk);
    sizeSwitches <= 10'b0_01_010_10_00;
    rd(6'h1c, 8'h12);
    rd(6'h1d, 8'h80);
  endtask

  task automatic test_write_once();
    wr(6'h10, 8'h29);
    check(16'(memoryMap.ramBase), 16'h0005);
    check(16'(memoryMap.ramHighAlign), 16'h0001);
    wr(6'h10, 8'h50);
    rd(6'h10, 8'h29);
    wr(6'h13, 8'h0e);
    check(16'(memoryMap.externalStretch), 16'h0003);
    check(16'(memoryMap.programHighMapOnly), 16'h0001);
    check(16'(memoryMap.programMemoryEnable), 16'h0000);
    wr(6'h13, 8'h01);
    rd(6'h13, 8'h0e);
    wr(6'h12, 8'h20);
    check(16'(memoryMap.eepromBase), 16'h0004);
    check(16'(memoryMap.eepromEnable), 16'h0000);
    wr(6'h12, 8'h31);
    rd(6'h12, 8'h31);
    check(16'(memoryMap.eepromEnable), 16'h0001);
    wr(6'h30, 8'hff);
    rd(6'h30, 8'h3f);
    check(16'(memoryMap.programPage), 16'h003f);
    wr(6'h11, 8'h08);
    check(16'(memoryMap.registerSpaceBase), 16'h0001);
    blk = 5'h01;
    rd(6'h11, 8'h08);
    wr(6'h11, 8'h10);
    rd(6'h11, 8'h08);
    blk = 5'h00;
    rd(6'h11, 8'h00);
    blk = 5'h01;
  endtask

  // stretch was left at 3; only expanded modes may pass it on
  task automatic test_stretch_modes();
    for (int m = 0; m < 7; m++) begin
      @(posedge clk);
      mode <= memory_map_control_pkg::op_mode_t'(m);
      repeat (2) @(posedge clk);
      #1 check(16'(memoryMap.externalStretch), (m == 1 || m == 3 || m == 5) ? 16'h0003 : 16'h0000);
    end
  endtask

  task automatic test_special_mode();
    do_reset();
    mode <= memory_map_control_pkg::MODE_SPECIAL_EXPANDED;
    rd(6'h10, 8'h09);
    wr(6'h11, 8'hff);
    check(16'(memoryMap.registerSpaceBase), 16'h000f);
    blk = 5'h0f;
    rd(6'h11, 8'h78);
    wr(6'h11, 8'h00);
    blk = 5'h00;
    rd(6'h11, 8'h00);
    wr(6'h10, 8'hff);
    rd(6'h10, 8'hf9);
    wr(6'h10, 8'h00);
    check(16'(memoryMap.ramBase), 16'h0000);
    check(16'(memoryMap.ramHighAlign), 16'h0000);
    rd(6'h10, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(6'h13, {4'h0, 2'(c), 2'b11});
      check(16'(memoryMap.externalStretch), 16'(c));
      rd(6'h13, {4'h0, 2'(c), 2'b11});
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    badCount++;
    summarize();
  end

  initial begin
    badCount = 0;
    checkCount = 0;
    reset_n = 1'b0;
    mode = memory_map_control_pkg::MODE_NORMAL_EXPANDED;
    sizeSwitches = '0;
    request = '0;
    blk = 5'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    test_reset_values();
    test_size_switches();
    test_write_once();
    test_stretch_modes();
    test_special_mode();
    summarize();
  end
endmodule

// ---- verilog/memory_map_control_defines.svh ----
`ifndef MEMORY_MAP_CONTROL_DEFINES_SVH
`define MEMORY_MAP_CONTROL_DEFINES_SVH

// register offsets inside the relocatable register block
`define MMC_OFF_RAM_POSITION 6'h10
`define MMC_OFF_REG_POSITION 6'h11
`define MMC_OFF_EEPROM_POSITION 6'h12
`define MMC_OFF_MISC_CONTROL 6'h13
`define MMC_OFF_TEST_A 6'h14
`define MMC_OFF_TEST_B 6'h17
`define MMC_OFF_SIZE_A 6'h1c
`define MMC_OFF_SIZE_B 6'h1d
`define MMC_OFF_PAGE_INDEX 6'h30
`define MMC_OFF_PAGE_RESERVED 6'h31

// field positions
`define MMC_POS_BASE_HI 7
`define MMC_POS_BASE_LO 3
`define MMC_POS_REG_HI 6
`define MMC_POS_RAM_HIGH_ALIGN 0
`define MMC_POS_EEPROM_ENABLE 0
`define MMC_POS_STRETCH_HI 3
`define MMC_POS_STRETCH_LO 2
`define MMC_POS_HIGH_MAP_ONLY 1
`define MMC_POS_PROGRAM_ENABLE 0
`define MMC_POS_PAGE_HI 5

// reset values, fixed at integration
`define MMC_RST_RAM_POSITION 8'h09
`define MMC_RST_REG_POSITION 8'h00
`define MMC_RST_EEPROM_POSITION 8'h01
`define MMC_RST_MISC_CONTROL 8'h01
`define MMC_RST_PAGE_INDEX 8'h00

// register block decode: five base bits above an 11-bit window
`define MMC_BLOCK_LSB 11
`define MMC_OFFSET_WIDTH 6

`endif

// ---- verilog/memory_map_control_pkg.sv ----
package memory_map_control_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL_SINGLE = 3'h0,
    MODE_NORMAL_EXPANDED = 3'h1,
    MODE_EMULATION_SINGLE = 3'h2,
    MODE_EMULATION_EXPANDED = 3'h3,
    MODE_SPECIAL_SINGLE = 3'h4,
    MODE_SPECIAL_EXPANDED = 3'h5,
    MODE_PERIPHERAL = 3'h6
  } op_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] writeData;
    logic writeStrobe;
    logic readStrobe;
  } reg_request_t;

  typedef struct packed {
    logic registerSpaceSizeSwitch;
    logic [1:0] eepromSizeSwitch;
    logic [2:0] ramSizeSwitch;
    logic [1:0] programSizeSwitch;
    logic [1:0] pagingSplitSwitch;
  } size_switches_t;

  typedef struct packed {
    logic [4:0] ramBase;
    logic ramHighAlign;
    logic [4:0] registerSpaceBase;
    logic [4:0] eepromBase;
    logic eepromEnable;
    logic [1:0] externalStretch;
    logic programHighMapOnly;
    logic programMemoryEnable;
    logic [5:0] programPage;
  } memory_map_t;

endpackage

// ---- verilog/memory_map_control_regs.sv ----
// Functional notes
// - register block base follows the register-space position register
// - ram position bits 7..3 give the ram base upper five bits
// - ram high-align bit chooses low or high end of mappable space
// - ram position writes once in normal/emulation, freely in special modes
// - writes to position and misc registers take effect one cycle later
// - register space is 1K or 2K, placed on 2K boundaries below 32K
// - register position bits 6..3 with bit 7 zero form the base
// - register position writes once in normal/emulation, freely in special modes
// - eeprom position bits 7..3 give the eeprom base upper five bits
// - eeprom enable writable any time, maps or unmaps the eeprom
// - eeprom base bits free or write-once, chosen at integration
// - stretch field adds 0 to 3 bus cycles on external accesses
// - stretch has no effect in single chip and peripheral modes
// - stretch, high-map-only, program enable write once unless special mode
// - high-map-only blocks direct low-half program access, page window stays
// - program memory enable maps program memory when one
// - memory size registers read integration switches, writes ignored
// - register-space size switch reads 0 for 1K, 1 for 2K
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "memory_map_control_defines.svh"

module memory_map_control_regs #(
  parameter bit EEPROM_BASE_WRITE_ONCE = 1'b0,
  parameter bit PAGE_WRITE_SPECIAL_ONLY = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire memory_map_control_pkg::op_mode_t mode,
  input wire memory_map_control_pkg::size_switches_t sizeSwitches,
  input wire memory_map_control_pkg::reg_request_t request,
  output logic [7:0] readData,
  output memory_map_control_pkg::memory_map_t memoryMap
);

  typedef struct packed {
    logic [7:0] ramPosition;
    logic [7:0] registerSpacePosition;
    logic [7:0] eepromPosition;
    logic [7:0] miscControl;
    logic [7:0] pageIndex;
    logic ramWritten;
    logic registerWritten;
    logic eepromBaseWritten;
    logic miscWritten;
    logic [7:0] readData;
    memory_map_control_pkg::memory_map_t map;
  } state_t;

  state_t st;
  state_t next_st;
  logic special;
  logic noExternalBus;
  logic blockHit;
  logic [`MMC_OFFSET_WIDTH-1:0] offset;
  logic wrHit;
  logic rdHit;
  logic [7:0] sizeA;
  logic [7:0] sizeB;

  assign special = (mode == memory_map_control_pkg::MODE_SPECIAL_SINGLE) ||
                   (mode == memory_map_control_pkg::MODE_SPECIAL_EXPANDED) ||
                   (mode == memory_map_control_pkg::MODE_PERIPHERAL);
  assign noExternalBus = (mode == memory_map_control_pkg::MODE_NORMAL_SINGLE) ||
                         (mode == memory_map_control_pkg::MODE_EMULATION_SINGLE) ||
                         (mode == memory_map_control_pkg::MODE_SPECIAL_SINGLE) ||
                         (mode == memory_map_control_pkg::MODE_PERIPHERAL);

  // the whole block moves with the register-space base; only the first 64 bytes of the
  // 2K window are decoded, for a 1K space as for a 2K one
  assign blockHit = (request.addr[15:`MMC_BLOCK_LSB] == {1'b0,
                    st.registerSpacePosition[`MMC_POS_REG_HI:`MMC_POS_BASE_LO]}) &&
                    (request.addr[`MMC_BLOCK_LSB-1:`MMC_OFFSET_WIDTH] == '0);
  assign offset = request.addr[`MMC_OFFSET_WIDTH-1:0];
  assign wrHit = request.writeStrobe && blockHit;
  assign rdHit = request.readStrobe && blockHit;

  assign sizeA = {sizeSwitches.registerSpaceSizeSwitch, 1'b0, sizeSwitches.eepromSizeSwitch,
                  1'b0, sizeSwitches.ramSizeSwitch};
  assign sizeB = {sizeSwitches.programSizeSwitch, 4'h0, sizeSwitches.pagingSplitSwitch};

  always_comb begin
    next_st = st;
    next_st.readData = 8'h00;
    if (wrHit) begin
      if (offset == `MMC_OFF_RAM_POSITION) begin
        if (special || !st.ramWritten) begin
          next_st.ramPosition = {request.writeData[7:3], 2'b00, request.writeData[0]};
          next_st.ramWritten = 1'b1;
        end
      end else if (offset == `MMC_OFF_REG_POSITION) begin
        if (special || !st.registerWritten) begin
          next_st.registerSpacePosition = {1'b0, request.writeData[6:3], 3'b000};
          next_st.registerWritten = 1'b1;
        end
      end else if (offset == `MMC_OFF_EEPROM_POSITION) begin
        next_st.eepromPosition[`MMC_POS_EEPROM_ENABLE] = request.writeData[0];
        if (!EEPROM_BASE_WRITE_ONCE || special || !st.eepromBaseWritten) begin
          next_st.eepromPosition[7:3] = request.writeData[7:3];
          next_st.eepromBaseWritten = 1'b1;
        end
      end else if (offset == `MMC_OFF_MISC_CONTROL) begin
        // the three misc fields share the same rights, so one flag serves them
        if (special || !st.miscWritten) begin
          next_st.miscControl = {4'h0, request.writeData[3:0]};
          next_st.miscWritten = 1'b1;
        end
      end else if (offset == `MMC_OFF_PAGE_INDEX) begin
        if (!PAGE_WRITE_SPECIAL_ONLY || special) begin
          next_st.pageIndex = {2'b00, request.writeData[5:0]};
        end
      end
    end
    if (rdHit) begin
      if (offset == `MMC_OFF_RAM_POSITION) begin
        next_st.readData = st.ramPosition;
      end else if (offset == `MMC_OFF_REG_POSITION) begin
        next_st.readData = st.registerSpacePosition;
      end else if (offset == `MMC_OFF_EEPROM_POSITION) begin
        next_st.readData = st.eepromPosition;
      end else if (offset == `MMC_OFF_MISC_CONTROL) begin
        next_st.readData = st.miscControl;
      end else if (offset == `MMC_OFF_SIZE_A) begin
        next_st.readData = sizeA;
      end else if (offset == `MMC_OFF_SIZE_B) begin
        next_st.readData = sizeB;
      end else if (offset == `MMC_OFF_PAGE_INDEX) begin
        next_st.readData = st.pageIndex;
      end
    end
    // map outputs come from the next register values, so they change on the same edge as the registers
    next_st.map.ramBase = next_st.ramPosition[`MMC_POS_BASE_HI:`MMC_POS_BASE_LO];
    next_st.map.ramHighAlign = next_st.ramPosition[`MMC_POS_RAM_HIGH_ALIGN];
    next_st.map.registerSpaceBase = next_st.registerSpacePosition[`MMC_POS_BASE_HI:`MMC_POS_BASE_LO];
    next_st.map.eepromBase = next_st.eepromPosition[`MMC_POS_BASE_HI:`MMC_POS_BASE_LO];
    next_st.map.eepromEnable = next_st.eepromPosition[`MMC_POS_EEPROM_ENABLE];
    next_st.map.externalStretch = noExternalBus ? 2'b00 :
      next_st.miscControl[`MMC_POS_STRETCH_HI:`MMC_POS_STRETCH_LO];
    next_st.map.programHighMapOnly = next_st.miscControl[`MMC_POS_HIGH_MAP_ONLY];
    next_st.map.programMemoryEnable = next_st.miscControl[`MMC_POS_PROGRAM_ENABLE];
    next_st.map.programPage = next_st.pageIndex[`MMC_POS_PAGE_HI:0];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.ramPosition <= `MMC_RST_RAM_POSITION;
      st.registerSpacePosition <= `MMC_RST_REG_POSITION;
      st.eepromPosition <= `MMC_RST_EEPROM_POSITION;
      st.miscControl <= `MMC_RST_MISC_CONTROL;
      st.pageIndex <= `MMC_RST_PAGE_INDEX;
      st.map.ramBase <= 5'(`MMC_RST_RAM_POSITION >> `MMC_POS_BASE_LO);
      st.map.ramHighAlign <= 1'(`MMC_RST_RAM_POSITION);
      st.map.registerSpaceBase <= 5'(`MMC_RST_REG_POSITION >> `MMC_POS_BASE_LO);
      st.map.eepromBase <= 5'(`MMC_RST_EEPROM_POSITION >> `MMC_POS_BASE_LO);
      st.map.eepromEnable <= 1'(`MMC_RST_EEPROM_POSITION);
      st.map.programHighMapOnly <= 1'(`MMC_RST_MISC_CONTROL >> `MMC_POS_HIGH_MAP_ONLY);
      st.map.programMemoryEnable <= 1'(`MMC_RST_MISC_CONTROL);
      st.map.programPage <= 6'(`MMC_RST_PAGE_INDEX);
    end else begin
      st <= next_st;
    end
  end

  assign readData = st.readData;
  assign memoryMap = st.map;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [15:0] blockBase;
  assign blockBase = {1'b0, st.registerSpacePosition[6:3], 11'h000};

  property p_ram_once;
    wrHit && offset == `MMC_OFF_RAM_POSITION && st.ramWritten && !special |=> $stable(st.ramPosition);
  endproperty
  a_ram_once: assert property (p_ram_once) else $error("ram position rewritten");

  property p_reg_once;
    wrHit && offset == `MMC_OFF_REG_POSITION && st.registerWritten && !special
      |=> $stable(memoryMap.registerSpaceBase);
  endproperty
  a_reg_once: assert property (p_reg_once) else $error("register base rewritten");

  property p_misc_once;
    wrHit && offset == `MMC_OFF_MISC_CONTROL && st.miscWritten && !special
      |=> $stable(memoryMap.programMemoryEnable) && $stable(memoryMap.programHighMapOnly);
  endproperty
  a_misc_once: assert property (p_misc_once) else $error("misc control rewritten");

  property p_ram_effect;
    request.writeStrobe && request.addr == blockBase + 16'h0010 && special
      |=> memoryMap.ramBase == $past(request.writeData[7:3]) && memoryMap.ramHighAlign == $past(request.writeData[0]);
  endproperty
  a_ram_effect: assert property (p_ram_effect) else $error("ram map not updated");

  property p_eeprom_enable;
    request.writeStrobe && request.addr == blockBase + 16'h0012
      |=> memoryMap.eepromEnable == $past(request.writeData[0]);
  endproperty
  a_eeprom_enable: assert property (p_eeprom_enable) else $error("eeprom enable ignored");

  property p_no_stretch;
    noExternalBus |=> memoryMap.externalStretch == 2'b00;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("stretch in single chip");

  property p_size_read;
    request.readStrobe && request.addr == blockBase + 16'h001c
      |=> readData == {sizeSwitches.registerSpaceSizeSwitch, 1'b0, sizeSwitches.eepromSizeSwitch,
                       1'b0, sizeSwitches.ramSizeSwitch};
  endproperty
  a_size_read: assert property (p_size_read) else $error("size switches misread");

  property p_page_read;
    request.readStrobe && blockHit && (offset == `MMC_OFF_PAGE_INDEX || offset == `MMC_OFF_PAGE_RESERVED)
      |=> readData[7:6] == 2'b00;
  endproperty
  a_page_read: assert property (p_page_read) else $error("page upper bits set");

  property p_block_moves;
    request.readStrobe && request.addr[15:11] != {1'b0, st.registerSpacePosition[6:3]} |=> readData == 8'h00;
  endproperty
  a_block_moves: assert property (p_block_moves) else $error("read outside block answered");

  logic [3:0] writtenFlags;
  assign writtenFlags = {st.ramWritten, st.registerWritten, st.eepromBaseWritten, st.miscWritten};

  property p_ram_first;
    wrHit && offset == `MMC_OFF_RAM_POSITION && (special || !st.ramWritten)
      |=> memoryMap.ramBase == $past(request.writeData[7:3]);
  endproperty
  a_ram_first: assert property (p_ram_first) else $error("ram base not taken");

  property p_ram_align;
    wrHit && offset == `MMC_OFF_RAM_POSITION && (special || !st.ramWritten)
      |=> memoryMap.ramHighAlign == $past(request.writeData[0]);
  endproperty
  a_ram_align: assert property (p_ram_align) else $error("ram alignment not taken");

  property p_ram_read;
    rdHit && offset == `MMC_OFF_RAM_POSITION |=> readData[2:1] == 2'b00;
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("ram position spare bits set");

  property p_reg_effect;
    wrHit && offset == `MMC_OFF_REG_POSITION && special
      |=> memoryMap.registerSpaceBase == {1'b0, $past(request.writeData[6:3])};
  endproperty
  a_reg_effect: assert property (p_reg_effect) else $error("register base not taken");

  property p_reg_read;
    rdHit && offset == `MMC_OFF_REG_POSITION |=> readData[7] == 1'b0 && readData[2:0] == 3'b000;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register base off a 2K boundary");

  property p_reg_answer;
    rdHit && offset == `MMC_OFF_REG_POSITION |=> readData == $past(st.registerSpacePosition);
  endproperty
  a_reg_answer: assert property (p_reg_answer) else $error("register position misread");

  property p_read_idle;
    !rdHit |=> readData == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without a read");

  property p_eeprom_effect;
    wrHit && offset == `MMC_OFF_EEPROM_POSITION && (!EEPROM_BASE_WRITE_ONCE || special)
      |=> memoryMap.eepromBase == $past(request.writeData[7:3]);
  endproperty
  a_eeprom_effect: assert property (p_eeprom_effect) else $error("eeprom base not taken");

  property p_eeprom_read;
    rdHit && offset == `MMC_OFF_EEPROM_POSITION |=> readData == $past(st.eepromPosition);
  endproperty
  a_eeprom_read: assert property (p_eeprom_read) else $error("eeprom position misread");

  property p_high_map;
    wrHit && offset == `MMC_OFF_MISC_CONTROL && (special || !st.miscWritten)
      |=> memoryMap.programHighMapOnly == $past(request.writeData[1]);
  endproperty
  a_high_map: assert property (p_high_map) else $error("high map bit not taken");

  property p_program_enable;
    wrHit && offset == `MMC_OFF_MISC_CONTROL && (special || !st.miscWritten)
      |=> memoryMap.programMemoryEnable == $past(request.writeData[0]);
  endproperty
  a_program_enable: assert property (p_program_enable) else $error("program enable not taken");

  property p_stretch_follows;
    !noExternalBus |=> memoryMap.externalStretch == st.miscControl[`MMC_POS_STRETCH_HI:`MMC_POS_STRETCH_LO];
  endproperty
  a_stretch_follows: assert property (p_stretch_follows) else $error("stretch not passed on");

  property p_misc_read;
    rdHit && offset == `MMC_OFF_MISC_CONTROL |=> readData[7:4] == 4'h0;
  endproperty
  a_misc_read: assert property (p_misc_read) else $error("misc upper bits set");

  property p_page_effect;
    wrHit && offset == `MMC_OFF_PAGE_INDEX && (!PAGE_WRITE_SPECIAL_ONLY || special)
      |=> memoryMap.programPage == $past(request.writeData[5:0]);
  endproperty
  a_page_effect: assert property (p_page_effect) else $error("page index not taken");

  property p_spare_read;
    rdHit && (offset == `MMC_OFF_PAGE_RESERVED || offset == `MMC_OFF_TEST_A || offset == `MMC_OFF_TEST_B)
      |=> readData == 8'h00;
  endproperty
  a_spare_read: assert property (p_spare_read) else $error("spare location not zero");

  property p_size_b_read;
    rdHit && offset == `MMC_OFF_SIZE_B
      |=> readData == {sizeSwitches.programSizeSwitch, 4'h0, sizeSwitches.pagingSplitSwitch};
  endproperty
  a_size_b_read: assert property (p_size_b_read) else $error("program size switches misread");

  property p_size_reg_bit;
    rdHit && offset == `MMC_OFF_SIZE_A |=> readData[7] == sizeSwitches.registerSpaceSizeSwitch;
  endproperty
  a_size_reg_bit: assert property (p_size_reg_bit) else $error("register size switch misread");

  property p_size_no_write;
    wrHit && (offset == `MMC_OFF_SIZE_A || offset == `MMC_OFF_SIZE_B)
      |=> $stable({st.ramPosition, st.registerSpacePosition, st.eepromPosition, st.miscControl, st.pageIndex});
  endproperty
  a_size_no_write: assert property (p_size_no_write) else $error("size write changed a register");

  property p_flag_set;
    wrHit && offset == `MMC_OFF_RAM_POSITION |=> st.ramWritten;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("ram written flag not set");

  property p_flags_sticky;
    ($past(writtenFlags) & ~writtenFlags) == 4'h0;
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("written flag cleared");

  c_reg_move: cover property (wrHit && offset == `MMC_OFF_REG_POSITION ##1 $changed(memoryMap.registerSpaceBase));
  c_once_blocked: cover property (wrHit && offset == `MMC_OFF_RAM_POSITION && st.ramWritten && !special);
  c_stretch: cover property (memoryMap.externalStretch == 2'b11);
  c_size_read: cover property (rdHit && offset == `MMC_OFF_SIZE_B);
  c_page_write: cover property (wrHit && offset == `MMC_OFF_PAGE_INDEX);

endmodule
